// ==== tb/srm_fe_model.sv ====
// behavioural solar current front end for the range meter
`timescale 1ns/1ps
module srm_fe_model (
    input  wire logic       clk_sys_i,
    input  wire logic       meter_en_o,
    input  wire logic [3:0] range_lvl_o,
    input  wire logic [3:0] band_i,
    output logic            current_above_lvl_i
);
    logic t_q = 1'b0;
    always @(posedge clk_sys_i) t_q <= ~t_q;
    // comparator high for every probed level up to the band; noise while the meter is off
    assign current_above_lvl_i = meter_en_o ? (range_lvl_o <= band_i) : t_q;
endmodule // srm_fe_model

// ==== tb/srm_meter_chk.sv ====
// assertion checker on the range meter ports
`timescale 1ns/1ps
module srm_meter_chk (
    input wire logic       clk_sys_i,
    input wire logic       rstn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       storage_disconnected_i,
    input wire logic       storage_low_threshold_i,
    input wire logic       meter_en_o,
    input wire logic [3:0] range_lvl_o,
    input wire logic       result_invalid_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    wire ok = !(storage_disconnected_i && storage_low_threshold_i);
    wire wc = reg_wr_i && reg_addr_i == 8'h1c;
    wire rr = reg_rd_i && reg_addr_i == 8'h1d;
    property p_idle; !(reg_rd_i && reg_addr_i[7:1] == 7'h0e) |=> reg_rdata_o == 8'h00; endproperty
    property p_cfg; reg_rd_i && reg_addr_i == 8'h1c |=> !reg_rdata_o[7]; endproperty
    property p_res; rr |=> reg_rdata_o[7:5] == 3'b000; endproperty
    property p_auto; wc && reg_wdata_i == 8'h40 && ok && !meter_en_o |-> ##[1:3] meter_en_o ##[1:90] !meter_en_o;
    endproperty
    property p_manu;
        (wc && reg_wdata_i[6:4] == 3'b001 && ok) ##1 !wc |=>
            (meter_en_o && range_lvl_o == $past(reg_wdata_i[3:0], 2));
    endproperty
    property p_off; wc && reg_wdata_i == 8'h00 |-> ##[1:3] !meter_en_o; endproperty
    property p_refuse; wc && (|reg_wdata_i[6:5]) && !ok |-> ##2 result_invalid_o; endproperty
    property p_idle_busy; rr && !meter_en_o && !$past(meter_en_o) && !$past(meter_en_o, 2) |=> !reg_rdata_o[4];
    endproperty
    a_idle: assert property (p_idle) else $error("read data not zero");
    a_cfg: assert property (p_cfg) else $error("config top bit set");
    a_res: assert property (p_res) else $error("result top bits set");
    a_auto: assert property (p_auto) else $error("one-shot did not run and stop");
    a_manu: assert property (p_manu) else $error("manual level not driven");
    a_off: assert property (p_off) else $error("meter still on");
    a_refuse: assert property (p_refuse) else $error("refusal not flagged");
    a_idle_busy: assert property (p_idle_busy) else $error("busy while idle");
    c_auto: cover property (wc && reg_wdata_i == 8'h40 && ok);
    c_manu: cover property (wc && reg_wdata_i[6:4] == 3'b001 && ok);
    c_inv: cover property (result_invalid_o);
    c_rng: cover property (wc && reg_wdata_i == 8'h20 && ok);
endmodule // srm_meter_chk
bind srm_meter srm_meter_chk u_chk (
    .clk_sys_i               (clk_sys_i),
    .rstn_i                  (rstn_i),
    .reg_addr_i              (reg_addr_i),
    .reg_wdata_i             (reg_wdata_i),
    .reg_wr_i                (reg_wr_i),
    .reg_rd_i                (reg_rd_i),
    .reg_rdata_o             (reg_rdata_o),
    .storage_disconnected_i  (storage_disconnected_i),
    .storage_low_threshold_i (storage_low_threshold_i),
    .meter_en_o              (meter_en_o),
    .range_lvl_o             (range_lvl_o),
    .result_invalid_o        (result_invalid_o)
);

// ==== tb/srm_meter_tb_top.sv ====
// self-checking bench for the solar current range meter
`timescale 1ns/1ps
module srm_meter_tb_top;
    import srm_pkg::*;
    logic       clk_sys_i = 1'b0, rstn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, rd_q = 1'b0;
    logic       storage_disconnected_i = 1'b0, storage_low_threshold_i = 1'b0;
    logic       current_above_lvl_i, meter_en_o, result_invalid_o;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
    logic [3:0] range_lvl_o, band = 4'h0;
    logic [7:0] q[$];
    int         err_count = 0, num_checks = 0, seed = 27282, i;
    always #10 clk_sys_i = ~clk_sys_i;
    srm_meter #(.STEP_CYCLES(4)) dut (
        .clk_sys_i               (clk_sys_i),
        .rstn_i                  (rstn_i),
        .reg_addr_i              (reg_addr_i),
        .reg_wdata_i             (reg_wdata_i),
        .reg_wr_i                (reg_wr_i),
        .reg_rd_i                (reg_rd_i),
        .reg_rdata_o             (reg_rdata_o),
        .storage_disconnected_i  (storage_disconnected_i),
        .storage_low_threshold_i (storage_low_threshold_i),
        .current_above_lvl_i     (current_above_lvl_i),
        .meter_en_o              (meter_en_o),
        .range_lvl_o             (range_lvl_o),
        .result_invalid_o        (result_invalid_o)
    );
    srm_fe_model fe (
        .clk_sys_i           (clk_sys_i),
        .meter_en_o          (meter_en_o),
        .range_lvl_o         (range_lvl_o),
        .band_i              (band),
        .current_above_lvl_i (current_above_lvl_i)
    );
    task automatic cmp(input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i) begin reg_addr_i <= a; reg_wdata_i <= d; reg_wr_i <= 1'b1; end
        @(posedge clk_sys_i) reg_wr_i <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys_i) begin reg_addr_i <= a; reg_rd_i <= 1'b1; q.push_back(e); end
        @(posedge clk_sys_i) reg_rd_i <= 1'b0;
    endtask
    task automatic wt(input logic v);
        for (int k = 0; k < 200 && meter_en_o !== v; k++) @(posedge clk_sys_i);
        cmp({7'h0, v}, {7'h0, meter_en_o});
    endtask
    task automatic meas(input logic [3:0] bb);
        logic [3:0] prev;
        prev = band;
        band <= bb;
        wrr(SRM_ADDR_CFG, 8'h40);
        wt(1'b1);
        rdc(SRM_ADDR_RESULT, {4'h1, prev});
        wt(1'b0);
        repeat (3) @(posedge clk_sys_i);
        rdc(SRM_ADDR_CFG, 8'h00);
        rdc(SRM_ADDR_RESULT, {4'h0, bb});
    endtask
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // read results leave the queue one cycle after each read strobe
    always @(posedge clk_sys_i) begin
        rd_q <= reg_rd_i;
        if (rd_q) cmp(q.pop_front(), reg_rdata_o);
    end
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        err_count++;
        conclude();
    end
    initial begin
        repeat (5) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        rdc(SRM_ADDR_CFG, SRM_CFG_RESET);
        rdc(SRM_ADDR_RESULT, 8'h00);
        rdc(8'h1e, 8'h00);
        $display("reset test done");
        meas(SRM_LVL_LOWEST);
        meas(SRM_LVL_HIGHEST);
        for (i = 0; i < 6; i++) meas(4'($random(seed)));
        $display("auto test done");
        for (i = 0; i < 16; i++) begin
            wrr(SRM_ADDR_CFG, 8'h10 | i[7:0]);
            wt(1'b1);
            repeat (2) @(posedge clk_sys_i);
            cmp({4'h0, i[3:0]}, {4'h0, range_lvl_o});
            rdc(SRM_ADDR_CFG, 8'h10 | i[7:0]);
            rdc(SRM_ADDR_RESULT, {4'h0, band});
        end
        wrr(SRM_ADDR_CFG, 8'h00);
        wt(1'b0);
        $display("manual test done");
        band <= 4'($random(seed));
        wrr(SRM_ADDR_CFG, 8'h20);
        wt(1'b1);
        repeat (150) @(posedge clk_sys_i);
        cmp(8'h01, {7'h0, meter_en_o});
        wrr(SRM_ADDR_CFG, 8'h00);
        wt(1'b0);
        repeat (3) @(posedge clk_sys_i);
        rdc(SRM_ADDR_RESULT, {4'h0, band});
        $display("auto range test done");
        storage_disconnected_i <= 1'b1;
        storage_low_threshold_i <= 1'b1;
        wrr(SRM_ADDR_CFG, 8'h40);
        repeat (3) @(posedge clk_sys_i);
        cmp({7'h0, 1'b1}, {7'h0, result_invalid_o});
        cmp(8'h00, {7'h0, meter_en_o});
        rdc(SRM_ADDR_CFG, 8'h00);
        storage_disconnected_i <= 1'b0;
        storage_low_threshold_i <= 1'b0;
        meas(4'h9);
        cmp(8'h00, {7'h0, result_invalid_o});
        $display("refusal test done");
        conclude();
    end
endmodule // srm_meter_tb_top

// ==== verilog/srm_meter.sv ====
// control and result logic of the solar current range meter
`timescale 1ns/1ps
module srm_meter
    import srm_pkg::*;
#(
    parameter int STEP_CYCLES = srm_pkg::SRM_STEP_CYCLES
) (
    input  wire logic       clk_sys_i,
    input  wire logic       rstn_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    input  wire logic       storage_disconnected_i,
    input  wire logic       storage_low_threshold_i,
    input  wire logic       current_above_lvl_i,
    output logic            meter_en_o,
    output logic      [3:0] range_lvl_o,
    output logic            result_invalid_o
);
    import srm_pkg::*;

    // ****************************************
    // registers and combinational signals
    // ****************************************
    srm_cfg_t   cfg_q;
    srm_res_t   res_q;
    srm_state_t state_q;
    logic [3:0] probe_q;
    logic [3:0] best_q;
    logic       tick;
    logic       cfg_wr;
    logic       blocked;
    logic       any_auto;
    logic       refuse_auto;
    logic       busy_d;
    logic       meter_en_d;
    logic [3:0] range_lvl_d;
    logic [7:0] rdata_d;

    // ****************************************
    // helpers
    // ****************************************
    // a mode bit is granted only while the storages can feed the meter
    function automatic logic grant(input logic [7:0] d, input int pos, input logic blk);
        return d[pos] && !blk;
    endfunction

    // true when a write asks for one of the automatic modes
    function automatic logic auto_request(input logic [7:0] d);
        return d[SRM_CFG_AUTO_MEAS] || d[SRM_CFG_AUTO_RNG];
    endfunction

    // byte image of the configuration register, reserved top bit reads zero
    function automatic logic [7:0] cfg_image(input srm_cfg_t c);
        logic [7:0] b;
        b                    = 8'h00;
        b[SRM_CFG_AUTO_MEAS] = c.auto_meas;
        b[SRM_CFG_AUTO_RNG]  = c.auto_rng;
        b[SRM_CFG_MANU]      = c.manu;
        b[3:0]               = c.lvl;
        return b;
    endfunction

    // byte image of the result register, reserved bits read zero
    function automatic logic [7:0] res_image(input srm_res_t r);
        logic [7:0] b;
        b               = 8'h00;
        b[SRM_RES_BUSY] = r.busy;
        b[3:0]          = r.code;
        return b;
    endfunction

    assign cfg_wr      = reg_wr_i && (reg_addr_i == SRM_ADDR_CFG);
    assign blocked     = storage_disconnected_i && storage_low_threshold_i;
    assign any_auto    = cfg_q.auto_meas || cfg_q.auto_rng;
    assign refuse_auto = cfg_wr && blocked && auto_request(reg_wdata_i);

    srm_step_tick #(
        .STEP_CYCLES (STEP_CYCLES)
    ) u_tick (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .run_i     (state_q == SRM_SEARCH),
        .tick_o    (tick)
    );

    // ****************************************
    // configuration register
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cfg_q <= srm_cfg_t'(SRM_CFG_RESET[6:0]);
        end else if (cfg_wr) begin
            cfg_q.lvl      <= reg_wdata_i[3:0];
            cfg_q.manu      <= grant(reg_wdata_i, SRM_CFG_MANU, blocked);
            cfg_q.auto_rng  <= grant(reg_wdata_i, SRM_CFG_AUTO_RNG, blocked);
            cfg_q.auto_meas <= grant(reg_wdata_i, SRM_CFG_AUTO_MEAS, blocked);
        end else if (state_q == SRM_DONE && cfg_q.auto_meas && !cfg_q.auto_rng) begin
            cfg_q.auto_meas <= 1'b0;
        end
    end

    // ****************************************
    // range search state machine
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= SRM_IDLE;
            probe_q <= SRM_LVL_LOWEST;
            best_q  <= SRM_RESULT_RESET;
        end else begin
            unique case (state_q)
                SRM_IDLE: begin
                    probe_q <= SRM_LVL_LOWEST;
                    best_q  <= SRM_RESULT_RESET;
                    if (any_auto) begin
                        state_q <= SRM_SEARCH;
                    end
                end
                SRM_SEARCH: begin
                    if (!any_auto) begin
                        state_q <= SRM_IDLE;
                    end else if (tick) begin
                        if (current_above_lvl_i) begin
                            best_q <= probe_q;
                        end
                        if (!current_above_lvl_i || probe_q == SRM_LVL_HIGHEST) begin
                            state_q <= SRM_DONE;
                        end else begin
                            probe_q <= probe_q + 4'h1;
                        end
                    end
                end
                SRM_DONE: begin
                    probe_q <= SRM_LVL_LOWEST;
                    state_q <= cfg_q.auto_rng ? SRM_SEARCH : SRM_IDLE;
                end
                default: state_q <= SRM_IDLE;
            endcase
        end
    end

    // ****************************************
    // result register
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            res_q <= '{busy: 1'b0, invalid: 1'b0, code: SRM_RESULT_RESET};
        end else begin
            res_q.busy <= busy_d;
            if (refuse_auto) begin
                res_q.invalid <= 1'b1;
            end else if (state_q == SRM_DONE) begin
                res_q.invalid <= 1'b0;
                res_q.code    <= best_q;
            end
        end
    end

    // ****************************************
    // next values of the outputs
    // ****************************************
    always_comb begin
        busy_d      = (state_q == SRM_SEARCH) && any_auto;
        // a continuous search keeps the front end on across the done cycle
        meter_en_d  = cfg_q.manu || (state_q == SRM_SEARCH) ||
                      ((state_q == SRM_DONE) && cfg_q.auto_rng);
        range_lvl_d = cfg_q.manu ? cfg_q.lvl : probe_q;
        rdata_d     = 8'h00;
        if (reg_rd_i && reg_addr_i == SRM_ADDR_CFG) begin
            rdata_d = cfg_image(cfg_q);
        end else if (reg_rd_i && reg_addr_i == SRM_ADDR_RESULT) begin
            rdata_d = res_image(res_q);
        end
    end

    // ****************************************
    // front end drive and invalid flag
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meter_en_o <= 1'b0;
        end else begin
            meter_en_o <= meter_en_d;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            range_lvl_o <= SRM_LVL_LOWEST;
        end else begin
            range_lvl_o <= range_lvl_d;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            result_invalid_o <= 1'b0;
        end else begin
            result_invalid_o <= res_q.invalid;
        end
    end

    // ****************************************
    // read data, zero outside a read
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= rdata_d;
        end
    end
endmodule // srm_meter

// ==== verilog/srm_pkg.sv ====
// package for the solar current range meter: register map, fields, states, timing
package srm_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] SRM_ADDR_CFG    = 8'h1c;
    localparam logic [7:0] SRM_ADDR_RESULT = 8'h1d;
    // ****************************************
    // field positions
    // ****************************************
    localparam int SRM_CFG_AUTO_MEAS = 6;
    localparam int SRM_CFG_AUTO_RNG  = 5;
    localparam int SRM_CFG_MANU      = 4;
    localparam int SRM_RES_BUSY      = 4;
    // ****************************************
    // reset values and codes
    // ****************************************
    localparam logic [7:0] SRM_CFG_RESET    = 8'h00;
    localparam logic [3:0] SRM_RESULT_RESET = 4'h0;
    localparam logic [3:0] SRM_LVL_LOWEST   = 4'h0;
    localparam logic [3:0] SRM_LVL_HIGHEST  = 4'hf;
    // ****************************************
    // timing
    // ****************************************
    localparam int SRM_CLK_HZ      = 50_000_000;
    localparam int SRM_STEP_US     = 10;
    localparam int SRM_STEP_CYCLES = (SRM_STEP_US * (SRM_CLK_HZ / 1_000_000) > 0) ?
                                     SRM_STEP_US * (SRM_CLK_HZ / 1_000_000) : 1;
    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        SRM_IDLE   = 2'b00,
        SRM_SEARCH = 2'b01,
        SRM_DONE   = 2'b11
    } srm_state_t;
    typedef struct packed {
        logic       auto_meas;
        logic       auto_rng;
        logic       manu;
        logic [3:0] lvl;
    } srm_cfg_t;
    typedef struct packed {
        logic       busy;
        logic       invalid;
        logic [3:0] code;
    } srm_res_t;
endpackage

// ==== verilog/srm_step_tick.sv ====
// divider that pulses once per range search step
`timescale 1ns/1ps
module srm_step_tick #(
    parameter int STEP_CYCLES = srm_pkg::SRM_STEP_CYCLES
) (
    input  wire logic clk_sys_i,
    input  wire logic rstn_i,
    input  wire logic run_i,
    output logic      tick_o
);
    import srm_pkg::*;
    localparam int CW = $clog2(STEP_CYCLES + 1);
    logic [CW-1:0] cnt_q;

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_q  <= '0;
            tick_o <= 1'b0;
        end else if (!run_i) begin
            cnt_q  <= '0;
            tick_o <= 1'b0;
        end else if (cnt_q == CW'(STEP_CYCLES - 1)) begin
            cnt_q  <= '0;
            tick_o <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + CW'(1);
            tick_o <= 1'b0;
        end
    end
endmodule // srm_step_tick
